// ### acsf_dev.sv
// The APB interface to the registers was chosen for this implementation.
`default_nettype none
module acsf_dev (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Serial link
  acsf_link_if.dev link,
  // Converter core side
  input wire logic clock_valid,
  input wire logic [3:0] over_full_scale,
  input wire logic [3:0] beyond_trip,
  input wire logic result_strobe,
  input wire logic [95:0] result_in,
  // Settings to the converter core
  output logic [7:0] cfg_out,
  output logic [15:0] rate_out,
  output logic [3:0][12:0] ch_delay_cycles,
  output logic realign,
  output logic fastest_rate
);
  import acsf_pkg::*;

  typedef struct packed {
    logic cs1;
    logic cs2;
    logic cs3;
    logic ck1;
    logic ck2;
    logic ck3;
    logic di1;
    logic di2;
    logic [6:0] bits;
    logic [7:0] cmd;
    logic [31:0] rx;
    logic [95:0] tx;
    logic dout;
    logic dout_oe;
    logic done;
    logic [31:0] phase;
    logic [15:0] rate;
    logic [7:0] cfg;
    logic [95:0] data;
    logic [LATENCY_PERIODS-1:0] ovr_pipe;
    logic fault;
    logic [4:0] rec_cnt;
    logic ovr_n;
    logic fault_n;
    logic rdy_n;
    logic [2:0] rdy_cnt;
    logic [3:0][12:0] delays;
    logic realign;
    logic fastest;
  } acsf_dev_t;

  acsf_dev_t s;
  acsf_dev_t next_s;
  logic rise;
  logic fall;
  logic cs_rise;
  logic [6:0] len;
  logic [6:0] total;
  logic is_write;
  logic [6:0] new_addr;
  logic trip;

  assign rise = s.ck2 & ~s.ck3;
  assign fall = ~s.ck2 & s.ck3;
  assign cs_rise = s.cs2 & ~s.cs3;
  assign len = acsf_data_len(s.cmd[6:0]);
  assign total = 7'(CMD_LEN + len);
  // Data register has no write command
  assign is_write = !s.cmd[CMD_RW_BIT] && len != 7'h00
    && s.cmd[6:0] != ADDR_DATA;
  assign new_addr = {s.cmd[5:0], s.di2};
  assign trip = |beyond_trip && !s.cfg[CFG_PROT_DIS_BIT];

  always_comb begin
    next_s = s;
    next_s.realign = 1'b0;
    next_s.cs1 = link.cs_n;
    next_s.cs2 = s.cs1;
    next_s.cs3 = s.cs2;
    next_s.ck1 = link.sclk;
    next_s.ck2 = s.ck1;
    next_s.ck3 = s.ck2;
    next_s.di1 = link.din;
    next_s.di2 = s.di1;

    // Fault tracking; recovery counted in output periods
    if (trip) begin
      next_s.fault = 1'b1;
      next_s.rec_cnt = 5'h00;
    end else if (s.cfg[CFG_PROT_DIS_BIT]) begin
      next_s.fault = 1'b0;
      next_s.rec_cnt = 5'h00;
    end else if (s.fault && result_strobe) begin
      next_s.rec_cnt = s.rec_cnt + 5'h01;
      // Partial first period puts release inside 21..22 periods
      if (s.rec_cnt == RECOVERY_PERIODS - 5'h01) begin
        next_s.fault = 1'b0;
      end
    end
    // Early jump to full scale as soon as the fault trips
    if (trip && !s.fault) begin
      next_s.data = {4{FULL_SCALE}};
    end
    if (result_strobe) begin
      next_s.ovr_pipe = {s.ovr_pipe[LATENCY_PERIODS-2:0],
        |over_full_scale};
      // New result replaces the old one; full scale is stored instead while faulted
      next_s.data = next_s.fault ? {4{FULL_SCALE}} : result_in;
      if (!link.result_ready_in_n) begin
        next_s.rdy_n = 1'b1;
        next_s.rdy_cnt = DRDY_HIGH_CYC;
      end
    end else if (s.rdy_cnt != 3'h0) begin
      next_s.rdy_cnt = s.rdy_cnt - 3'h1;
      if (s.rdy_cnt == 3'h1) begin
        next_s.rdy_n = 1'b0;
      end
    end
    if (!clock_valid) begin
      next_s.ovr_n = 1'b1;
      next_s.ovr_pipe = '0;
    end else begin
      next_s.ovr_n = !(next_s.ovr_pipe[LATENCY_PERIODS-1]
        || next_s.fault);
    end
    next_s.fault_n = !next_s.fault;
    // Flag to the converter core: protection advised off at fastest rate
    next_s.fastest = s.rate[COARSE_LSB +: 3] == COARSE_FASTEST;

    for (int i = 0; i < 4; i++) begin
      next_s.delays[3-i] = 13'({s.phase[8*i +: 8], 5'h00});
    end

    // Serial port
    if (s.cs2) begin
      next_s.bits = 7'h00;
      next_s.dout_oe = 1'b0;
      next_s.dout = 1'b0;
      next_s.done = 1'b0;
    end else begin
      next_s.dout_oe = 1'b1;
      if (fall && (s.bits < CMD_LEN || s.bits < total)) begin
        next_s.bits = s.bits + 7'h01;
        if (s.bits < CMD_LEN) begin
          next_s.cmd = {s.cmd[6:0], s.di2};
          if (s.bits == CMD_LEN - 7'h01) begin
            case (new_addr)
              ADDR_PHASE: next_s.tx = {s.phase, 64'h0};
              ADDR_RATE: next_s.tx = {s.rate, 80'h0};
              ADDR_CFG: next_s.tx = {s.cfg, 88'h0};
              ADDR_DATA: next_s.tx = s.data;
              default: next_s.tx = 96'h0;
            endcase
          end
        end else begin
          next_s.rx = {s.rx[30:0], s.di2};
        end
      end
      if (rise && s.bits >= CMD_LEN && s.cmd[CMD_RW_BIT]) begin
        next_s.dout = s.tx[95];
        next_s.tx = {s.tx[94:0], 1'b0};
      end
    end

    // Commit on the final rising edge, or at deselect after a
    // mode 0 transfer; short transfers never reach this
    if (!s.done && s.bits == total && is_write
        && ((rise && !s.cs2) || cs_rise)) begin
      next_s.done = 1'b1;
      case (s.cmd[6:0])
        ADDR_PHASE: next_s.phase = s.rx;
        ADDR_RATE: next_s.rate = s.rx[15:0];
        ADDR_CFG: begin
          next_s.cfg = s.rx[7:0];
          if (s.rx[CFG_RST_BIT]) begin
            next_s.cfg = CFG_RESET;
            next_s.cfg[CFG_RST_BIT] = 1'b1;
            next_s.phase = PHASE_RESET;
            next_s.rate = RATE_RESET;
            next_s.data = 96'h0;
            next_s.ovr_pipe = '0;
            // A trip in the same cycle still wins
            next_s.fault = trip;
            next_s.rec_cnt = 5'h00;
            next_s.realign = 1'b1;
          end
        end
        default: next_s.done = 1'b1;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      s <= '0;
      s.cs1 <= 1'b1;
      s.cs2 <= 1'b1;
      s.cs3 <= 1'b1;
      s.ovr_n <= 1'b1;
      s.fault_n <= 1'b1;
      s.rdy_n <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign link.dout = s.dout;
  assign link.dout_oe = s.dout_oe;
  // No cascade: next device would see an idle chain
  assign link.chain_out = 1'b0;
  assign link.result_ready_out_n = s.rdy_n;
  assign link.range_overflow_n = s.ovr_n;
  assign link.fault_n = s.fault_n;
  assign cfg_out = s.cfg;
  assign rate_out = s.rate;
  assign ch_delay_cycles = s.delays;
  assign realign = s.realign;
  assign fastest_rate = s.fastest;
endmodule
`default_nettype wire

// ### acsf_pkg.sv
`default_nettype none
package acsf_pkg;
  localparam int CMD_RW_BIT = 7;
  localparam logic [6:0] ADDR_PHASE = 7'h40;
  localparam logic [6:0] ADDR_RATE = 7'h50;
  localparam logic [6:0] ADDR_CFG = 7'h60;
  localparam logic [6:0] ADDR_DATA = 7'h70;
  localparam logic [6:0] CMD_LEN = 7'h08;
  localparam logic [6:0] LEN_PHASE = 7'h20;
  localparam logic [6:0] LEN_RATE = 7'h10;
  localparam logic [6:0] LEN_CFG = 7'h08;
  localparam logic [6:0] LEN_DATA = 7'h60;
  localparam logic [31:0] PHASE_RESET = 32'h0000_0000;
  localparam logic [15:0] RATE_RESET = 16'h0000;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam int CFG_RST_BIT = 6;
  localparam int CFG_PROT_DIS_BIT = 3;
  localparam int COARSE_LSB = 13;
  localparam logic [2:0] COARSE_FASTEST = 3'h7;
  localparam int PHASE_STEP_SHIFT = 5;
  localparam int LATENCY_PERIODS = 6;
  localparam logic [4:0] RECOVERY_PERIODS = 5'h16;
  localparam logic [23:0] FULL_SCALE = 24'h7f_ffff;
  localparam int MCLK_PERIOD_NS = 25;
  localparam int DRDY_HIGH_NS = 100;
  localparam logic [2:0] DRDY_HIGH_CYC = 3'(DRDY_HIGH_NS / MCLK_PERIOD_NS);
  localparam int SCLK_HALF_NS = 200;
  localparam logic [3:0] SCLK_HALF_CYC = 4'(SCLK_HALF_NS / MCLK_PERIOD_NS);
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_WDATA = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_RDATA0 = 8'h0c;
  localparam logic [7:0] REG_RDATA1 = 8'h10;
  localparam logic [7:0] REG_RDATA2 = 8'h14;
  localparam int CTRL_START_BIT = 8;
  localparam int CTRL_MODE3_BIT = 9;

  function automatic logic [6:0] acsf_data_len(input logic [6:0] addr);
    case (addr)
      ADDR_PHASE: return LEN_PHASE;
      ADDR_RATE: return LEN_RATE;
      ADDR_CFG: return LEN_CFG;
      ADDR_DATA: return LEN_DATA;
      default: return 7'h00;
    endcase
  endfunction
endpackage
`default_nettype wire

// ### acsf_link_if.sv
`default_nettype none
interface acsf_link_if;
  logic cs_n;
  logic sclk;
  logic din;
  logic dout;
  logic dout_oe;
  logic dout_line;
  logic chain_in;
  logic chain_out;
  logic result_ready_in_n;
  logic result_ready_out_n;
  logic range_overflow_n;
  logic fault_n;

  // Released line reads low, like a weak pull-down
  assign dout_line = dout_oe & dout;

  modport dev(input cs_n, input sclk, input din, input chain_in,
    input result_ready_in_n, output dout, output dout_oe,
    output chain_out, output result_ready_out_n,
    output range_overflow_n, output fault_n);
  modport host(output cs_n, output sclk, output din, output chain_in,
    output result_ready_in_n, input dout_line, input chain_out,
    input result_ready_out_n, input range_overflow_n, input fault_n);
endinterface
`default_nettype wire

// ### acsf_host.sv
`default_nettype none
module acsf_host (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Serial link
  acsf_link_if.host link
);
  import acsf_pkg::*;

  typedef enum logic [1:0] {HS_IDLE, HS_LEAD, HS_CLK, HS_TAIL} acsf_hstate_t;

  typedef struct packed {
    acsf_hstate_t st;
    logic cs_n;
    logic sclk;
    logic din;
    logic mode3;
    logic [3:0] half;
    logic [6:0] falls;
    logic [6:0] total;
    logic [7:0] cmd;
    logic [39:0] tx;
    logic [95:0] rx;
    logic [31:0] wdata;
    logic do1;
    logic do2;
    logic [2:0] fl1;
    logic [2:0] fl2;
    logic [31:0] prdata;
    logic pready;
  } acsf_host_t;

  acsf_host_t s;
  acsf_host_t next_s;
  logic [6:0] new_len;

  assign new_len = acsf_data_len(pwdata[6:0]);

  always_comb begin
    next_s = s;
    next_s.do1 = link.dout_line;
    next_s.do2 = s.do1;
    next_s.fl1 = {link.range_overflow_n, link.fault_n,
      link.result_ready_out_n};
    next_s.fl2 = s.fl1;
    // APB: one wait-free answer, data prepared in setup cycle
    next_s.pready = 1'b0;
    if (psel && !penable) begin
      next_s.pready = 1'b1;
      case (paddr)
        REG_CTRL: next_s.prdata = {22'h0, s.mode3, 1'b0, s.cmd};
        REG_WDATA: next_s.prdata = s.wdata;
        REG_STATUS: next_s.prdata = {28'h0, s.fl2, s.st != HS_IDLE};
        REG_RDATA0: next_s.prdata = s.rx[31:0];
        REG_RDATA1: next_s.prdata = s.rx[63:32];
        REG_RDATA2: next_s.prdata = s.rx[95:64];
        default: next_s.prdata = 32'h0;
      endcase
    end
    if (psel && penable && s.pready && pwrite) begin
      if (paddr == REG_WDATA) begin
        next_s.wdata = pwdata;
      end
      // Start ignored while busy
      if (paddr == REG_CTRL && s.st == HS_IDLE) begin
        next_s.mode3 = pwdata[CTRL_MODE3_BIT];
        if (pwdata[CTRL_START_BIT]) begin
          next_s.cmd = pwdata[7:0];
          next_s.total = 7'(CMD_LEN + new_len);
          // Command first, rw bit leading; data left aligned
          next_s.tx = {pwdata[7:0],
            32'(s.wdata << (7'h20 - new_len))};
          next_s.st = HS_LEAD;
          next_s.half = 4'h0;
          next_s.falls = 7'h00;
        end
      end
    end
    case (s.st)
      HS_IDLE: begin
        next_s.cs_n = 1'b1;
        next_s.sclk = next_s.mode3;
      end
      HS_LEAD: begin
        next_s.cs_n = 1'b0;
        next_s.half = s.half + 4'h1;
        if (s.half == 4'h0) begin
          next_s.din = s.tx[39];
          next_s.tx = {s.tx[38:0], 1'b0};
        end
        if (s.half == SCLK_HALF_CYC - 4'h1) begin
          next_s.half = 4'h0;
          next_s.st = HS_CLK;
        end
      end
      HS_CLK: begin
        next_s.half = s.half + 4'h1;
        if (s.half == SCLK_HALF_CYC - 4'h1) begin
          next_s.half = 4'h0;
          next_s.sclk = !s.sclk;
          if (s.sclk) begin
            // Falling edge: device data sampled here
            if (s.falls >= CMD_LEN) begin
              next_s.rx = {s.rx[94:0], s.do2};
            end
            next_s.falls = s.falls + 7'h01;
            if (s.falls + 7'h01 == s.total && !s.mode3) begin
              next_s.st = HS_TAIL;
            end
          end else begin
            // Rising edge: next bit out
            if (s.falls != 7'h00 && s.falls < s.total) begin
              next_s.din = s.tx[39];
              next_s.tx = {s.tx[38:0], 1'b0};
            end
            if (s.falls == s.total) begin
              next_s.st = HS_TAIL;
            end
          end
        end
      end
      HS_TAIL: begin
        next_s.half = s.half + 4'h1;
        if (s.half == SCLK_HALF_CYC - 4'h1) begin
          next_s.cs_n = 1'b1;
          next_s.st = HS_IDLE;
        end
      end
      default: next_s.st = HS_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      s <= '0;
      s.cs_n <= 1'b1;
      s.fl1 <= 3'h7;
      s.fl2 <= 3'h7;
    end else begin
      s <= next_s;
    end
  end

  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = 1'b0;
  assign link.cs_n = s.cs_n;
  assign link.sclk = s.sclk;
  assign link.din = s.din;
  // Single device: chain and ready inputs held low
  assign link.chain_in = 1'b0;
  assign link.result_ready_in_n = 1'b0;
endmodule
`default_nettype wire

// ### acsf_link_monitor.sv
`default_nettype none
module acsf_link_monitor (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Link
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic din,
  input wire logic dout_oe,
  input wire logic dout_line,
  input wire logic chain_out,
  input wire logic result_ready_out_n,
  input wire logic range_overflow_n,
  input wire logic fault_n,
  // Core side causes
  input wire logic clock_valid,
  input wire logic [3:0] beyond_trip,
  input wire logic result_strobe,
  input wire logic [7:0] cfg_out
);
  import acsf_pkg::*;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // Chip select passes a 2-flop sync, so allow a short lag
  property p_dout_released;
    cs_n [*4] |-> !dout_oe;
  endproperty
  a_dout_released: assert property (p_dout_released)
    else $error("data out driven while deselected");
  property p_chain_idle;
    chain_out == 1'b0;
  endproperty
  a_chain_idle: assert property (p_chain_idle)
    else $error("chain out not low");
  property p_sclk_half;
    !cs_n && $changed(sclk) |=> $stable(sclk) [*7];
  endproperty
  a_sclk_half: assert property (p_sclk_half)
    else $error("serial clock half period short");
  property p_din_hold;
    !cs_n && $fell(sclk) |-> $stable(din);
  endproperty
  a_din_hold: assert property (p_din_hold)
    else $error("data in moved at capture edge");
  property p_dout_hold;
    !cs_n && $fell(sclk) |-> $stable(dout_line);
  endproperty
  a_dout_hold: assert property (p_dout_hold)
    else $error("data out moved at capture edge");
  property p_trip;
    (|beyond_trip) && !cfg_out[CFG_PROT_DIS_BIT] |=> !fault_n;
  endproperty
  a_trip: assert property (p_trip)
    else $error("fault not raised on trip");
  property p_ovr_with_fault;
    $fell(fault_n) && clock_valid |-> !range_overflow_n;
  endproperty
  a_ovr_with_fault: assert property (p_ovr_with_fault)
    else $error("overflow not low with fault");
  property p_ovr_invalid;
    !clock_valid && !$past(clock_valid) |-> range_overflow_n;
  endproperty
  a_ovr_invalid: assert property (p_ovr_invalid)
    else $error("overflow low without valid clock");
  property p_no_fault;
    cfg_out[CFG_PROT_DIS_BIT] && $past(cfg_out[CFG_PROT_DIS_BIT])
      |-> fault_n;
  endproperty
  a_no_fault: assert property (p_no_fault)
    else $error("fault low with protection off");
  property p_ready_pulse;
    result_strobe |=> result_ready_out_n [*4] ##1 !result_ready_out_n;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse)
    else $error("ready out pulse wrong");
  c_fault: cover property (!fault_n);
  c_frame: cover property ($fell(cs_n));
  c_ovr: cover property (!range_overflow_n && fault_n);
endmodule
`default_nettype wire

// ### adc_serial_command_and_fault_flags_tb.sv
`default_nettype none
module adc_serial_command_and_fault_flags_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import acsf_pkg::*;
  logic mclk, rst_b, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr, cfg_out, cfg2;
  logic [31:0] pwdata, prdata, q;
  logic clock_valid, result_strobe, realign, fastest_rate;
  logic [3:0] over_full_scale, beyond_trip;
  logic [95:0] result_in;
  logic [15:0] rate_out;
  logic [3:0][12:0] ch_delay_cycles;
  int err_count, checks;
  int realigns = 0;
  acsf_link_if link();
  acsf_link_if link2();
  acsf_host acsf_host_inst (.mclk(mclk), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link));
  acsf_dev acsf_dev_inst (.mclk(mclk), .rst_b(rst_b), .link(link),
    .clock_valid(clock_valid), .over_full_scale(over_full_scale),
    .beyond_trip(beyond_trip), .result_strobe(result_strobe),
    .result_in(result_in), .cfg_out(cfg_out), .rate_out(rate_out),
    .ch_delay_cycles(ch_delay_cycles), .realign(realign),
    .fastest_rate(fastest_rate));
  // Second device faces a bench driver that can cut a frame short
  acsf_dev acsf_dev2_inst (.mclk(mclk), .rst_b(rst_b), .link(link2),
    .clock_valid(clock_valid), .over_full_scale(over_full_scale),
    .beyond_trip(beyond_trip), .result_strobe(result_strobe),
    .result_in(result_in), .cfg_out(cfg2), .rate_out(),
    .ch_delay_cycles(), .realign(), .fastest_rate());
  acsf_link_monitor acsf_link_monitor_inst (.mclk(mclk), .rst_b(rst_b),
    .cs_n(link.cs_n), .sclk(link.sclk), .din(link.din),
    .dout_oe(link.dout_oe), .dout_line(link.dout_line),
    .chain_out(link.chain_out),
    .result_ready_out_n(link.result_ready_out_n),
    .range_overflow_n(link.range_overflow_n), .fault_n(link.fault_n),
    .clock_valid(clock_valid), .beyond_trip(beyond_trip),
    .result_strobe(result_strobe), .cfg_out(cfg_out));

  // Realign is a one-cycle pulse, so count it as it goes by
  always @(posedge mclk) begin
    if (realign === 1'b1) begin
      realigns++;
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [7:0] a,
      input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    // No local limit: only the watchdog ends a hung wait
    while (pready !== 1'b1) begin
      @(posedge mclk);
    end
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  // Wide reads take about 1700 cycles, hence the roomy bound
  task automatic xfer(input logic [7:0] cmd, input logic [31:0] wd,
      input logic m3);
    apb(1'b1, REG_WDATA, wd);
    apb(1'b1, REG_CTRL, {22'h0, m3, 1'b1, cmd});
    q = 32'h1;
    while (q[0] !== 1'b0) begin
      apb(1'b0, REG_STATUS, 32'h0);
    end
    repeat (8) @(posedge mclk);
  endtask
  task automatic strobe(input int k);
    repeat (k) begin
      result_strobe <= 1'b1;
      @(posedge mclk);
      result_strobe <= 1'b0;
      repeat (40) @(posedge mclk);
    end
  endtask
  task automatic send2(input logic [15:0] b, input int n);
    link2.cs_n <= 1'b0;
    repeat (4) @(posedge mclk);
    for (int i = 15; i > 15 - n; i--) begin
      link2.sclk <= 1'b1;
      link2.din <= b[i];
      repeat (4) @(posedge mclk);
      link2.sclk <= 1'b0;
      repeat (4) @(posedge mclk);
    end
    link2.cs_n <= 1'b1;
    repeat (8) @(posedge mclk);
  endtask

  task automatic t_reset;
    check(32'(cfg_out), 32'h0);
    check(32'(rate_out), 32'h0);
    xfer(8'hc0, 32'h0, 1'b0);
    apb(1'b0, REG_RDATA0, 32'h0);
    check(q, 32'h0);
    apb(1'b0, 8'h20, 32'h0);
    check(q, 32'h0);
  endtask
  task automatic t_regs;
    xfer(8'h40, 32'h01020304, 1'b0);
    check(32'(ch_delay_cycles[3]), 32'h80);
    check(32'(ch_delay_cycles[0]), 32'h20);
    xfer(8'hc0, 32'h0, 1'b1);
    apb(1'b0, REG_RDATA0, 32'h0);
    check(q, 32'h01020304);
    xfer(8'h50, 32'he001, 1'b1);
    check(32'(rate_out), 32'he001);
    check(32'(fastest_rate), 32'h1);
    xfer(8'hd0, 32'h0, 1'b0);
    apb(1'b0, REG_RDATA0, 32'h0);
    check(q, 32'he001);
    xfer(8'h60, 32'h08, 1'b1);
    check(32'(cfg_out), 32'h08);
    xfer(8'h60, 32'h0, 1'b0);
  endtask
  task automatic t_abort;
    send2(16'h6008, 12);
    check(32'(cfg2), 32'h0);
    send2(16'h6008, 16);
    check(32'(cfg2), 32'h08);
  endtask
  task automatic t_data;
    result_in <= 96'h111111_222222_333333_444444;
    strobe(1);
    result_in <= 96'h0a0b0c_0d0e0f_102030_405060;
    strobe(1);
    xfer(8'hf0, 32'h0, 1'b0);
    apb(1'b0, REG_RDATA2, 32'h0);
    check(q, 32'h0a0b0c0d);
    apb(1'b0, REG_RDATA0, 32'h0);
    check(q, 32'h30405060);
  endtask
  task automatic t_overflow;
    over_full_scale <= 4'h1;
    for (int k = 1; k <= 8; k++) begin
      strobe(1);
      check(32'(link.range_overflow_n), 32'(k < LATENCY_PERIODS));
    end
    clock_valid <= 1'b0;
    strobe(2);
    check(32'(link.range_overflow_n), 32'h1);
    clock_valid <= 1'b1;
    over_full_scale <= 4'h0;
    strobe(8);
  endtask
  task automatic t_fault;
    beyond_trip <= 4'h2;
    repeat (3) @(posedge mclk);
    check(32'(link.fault_n), 32'h0);
    check(32'(link.range_overflow_n), 32'h0);
    beyond_trip <= 4'h0;
    strobe(1);
    xfer(8'hf0, 32'h0, 1'b0);
    apb(1'b0, REG_RDATA0, 32'h0);
    check(q, {FULL_SCALE[7:0], FULL_SCALE});
    for (int k = 2; k <= 24; k++) begin
      strobe(1);
      check(32'(link.fault_n), 32'(k >= 32'(RECOVERY_PERIODS)));
    end
    // Status: overflow and fault released, ready low, idle
    apb(1'b0, REG_STATUS, 32'h0);
    check(q, 32'h0000_000c);
    xfer(8'h60, 32'h08, 1'b0);
    beyond_trip <= 4'hf;
    strobe(1);
    check(32'(link.fault_n), 32'h1);
    xfer(8'hf0, 32'h0, 1'b0);
    apb(1'b0, REG_RDATA0, 32'h0);
    check(q, result_in[31:0]);
    beyond_trip <= 4'h0;
  endtask
  task automatic t_cfg_reset;
    xfer(8'h40, 32'haabbccdd, 1'b0);
    xfer(8'h60, 32'h40, 1'b1);
    check(32'(cfg_out), 32'h40);
    check(32'(ch_delay_cycles[3]), 32'h0);
    check(32'(rate_out), 32'h0);
    check(32'(realigns), 32'h1);
  endtask

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  initial begin
    #2000000;
    err_count++;
    report_and_stop;
  end
  initial begin
    err_count = 0;
    checks = 0;
    rst_b = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {clock_valid, result_strobe} = 2'b10;
    {over_full_scale, beyond_trip, result_in} = '0;
    {link2.cs_n, link2.sclk, link2.din} = 3'b100;
    {link2.chain_in, link2.result_ready_in_n} = 2'b00;
    repeat (3) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (4) @(posedge mclk);
    t_reset;
    $display("reset done");
    t_regs;
    $display("registers done");
    t_abort;
    $display("abort done");
    t_data;
    $display("data done");
    t_overflow;
    $display("overflow done");
    t_fault;
    $display("fault done");
    t_cfg_reset;
    $display("config reset done");
    report_and_stop;
  end
endmodule
`default_nettype wire
